/* File: include/ssar_pkg.sv */
// Package: register map, field layout and reset values of the status bank
package ssar_pkg;

  // Register addresses on the serial register port
  localparam logic [5:0] ADDR_SHARED_THRESHOLD_AND_MATRIX_FLAGS = 6'h09;
  localparam logic [5:0] ADDR_ADC_RESULT_INPUTS_0_1 = 6'h0A;
  localparam logic [5:0] ADDR_ADC_RESULT_INPUTS_2_3 = 6'h0B;
  localparam logic [5:0] ADDR_ADC_RESULT_INPUTS_4_5 = 6'h0C;
  localparam logic [5:0] ADDR_ADC_RESULT_INPUTS_6_7 = 6'h0D;
  localparam logic [5:0] ADDR_ADC_RESULT_INPUTS_8_9 = 6'h0E;

  // Widths
  localparam int REG_W      = 24;
  localparam int ADC_W      = 10;
  localparam int ADDR_W     = 6;
  localparam int NUM_CMP    = 12;
  localparam int NUM_DRIVE  = 6;
  localparam int NUM_PAIRS  = 5;

  // Field positions in the combined flag register
  localparam int CMP_LSB    = 12;
  localparam int CMP_MSB    = 23;
  localparam int S15_LSB    = 6;
  localparam int S15_MSB    = 11;
  localparam int S14_LSB    = 0;
  localparam int S14_MSB    = 5;

  // Field positions in an ADC result register
  localparam int EVEN_LSB   = 0;
  localparam int EVEN_MSB   = 9;
  localparam int ODD_LSB    = 10;
  localparam int ODD_MSB    = 19;
  localparam int RSV_LSB    = 20;
  localparam int RSV_MSB    = 23;

  // Reset values
  localparam logic [23:0] RST_FLAGS  = 24'h000000;
  localparam logic [9:0]  RST_CODE   = 10'h000;
  localparam logic [5:0]  RST_SCAN   = 6'h00;
  localparam logic [3:0]  RSV_VALUE  = 4'h0;
  localparam logic [23:0] READ_UNMAPPED = 24'h000000;

  // Scan capture states
  typedef enum logic [0:0] {
    SSAR_SCAN_IDLE = 1'b0,
    SSAR_SCAN_HOLD = 1'b1
  } ssar_scan_t;

endpackage

/* File: include/ssar_pair_if.sv */
// Interface: one ADC code pair travelling to its result register
`timescale 1ns/1ps
interface ssar_pair_if;
  logic       upd;       // Load strobe for this pair
  logic [9:0] code_even; // Even input code
  logic [9:0] code_odd;  // Odd input code
  logic [23:0] word;     // Packed register image

  modport src
  (
    output upd,
    output code_even,
    output code_odd,
    input  word
  );
  modport reg_side
  (
    input  upd,
    input  code_even,
    input  code_odd,
    output word
  );
endinterface

/* File: src/ssar_pair_reg.sv */
// Module: one read-only ADC result register packing two codes
`timescale 1ns/1ps
module ssar_pair_reg
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  ssar_pair_if.reg_side   pair
);

  logic [9:0] even_ff; // Even input code held
  logic [9:0] odd_ff;  // Odd input code held

  // -----------------------------------------------------------------
  // Code capture
  // -----------------------------------------------------------------
  // Both halves load together so a read never mixes two conversions
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      even_ff <= ssar_pkg::RST_CODE;
      odd_ff  <= ssar_pkg::RST_CODE;
    end
    else if (pair.upd)
    begin
      even_ff <= pair.code_even;
      odd_ff  <= pair.code_odd;
    end
  end

  // -----------------------------------------------------------------
  // Packing
  // -----------------------------------------------------------------
  // Reserved top nibble is a constant, never stored
  assign pair.word = {ssar_pkg::RSV_VALUE, odd_ff, even_ff};

endmodule

/* File: src/ssar_status_bank.sv */
// Module: read-only switch status and ADC readback register bank
//
// Summary of operation
// - Bits 23..12 flag inputs 11..0 at/above threshold
// - Bits 11..6 flag input 15 per drive 9..4
// - Bits 5..0 flag input 14 per drive 9..4
// - Even input code in bits 9..0
// - Odd input code in bits 19..10
// - All fields read-only, zero after reset
// - Result registers at Ah..Eh, ascending pairs
// - Combined flags at 9h, scan updates matrix flags
`timescale 1ns/1ps
module ssar_status_bank
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [9:0]  shared_threshold_level,
  input  wire logic [159:0] in_level,
  input  wire logic        cmp_upd,
  input  wire logic        scan_valid,
  input  wire logic [5:0]  scan_drive_onehot,
  input  wire logic        adc_upd,
  input  wire logic [99:0] adc_code,
  input  wire logic        rd_en,
  input  wire logic        wr_en,
  input  wire logic [5:0]  reg_addr,
  input  wire logic [23:0] wr_data,
  output logic      [23:0] rd_data,
  output logic             rd_valid,
  output logic             addr_err
);

  // -----------------------------------------------------------------
  // Storage
  // -----------------------------------------------------------------
  logic [11:0] cmp_ff;      // Shared-threshold flags, input 11..0
  logic [5:0]  s15_ff;      // Input 15 flags per drive 9..4
  logic [5:0]  s14_ff;      // Input 14 flags per drive 9..4
  logic [23:0] rd_data_ff;  // Read answer
  logic        rd_valid_ff; // Read answer valid
  logic        addr_err_ff; // Unmapped or write attempt
  logic [23:0] nxt_rd_data; // Decoded read word
  logic        nxt_hit;     // Address is mapped
  logic [23:0] flags_word;  // Combined flag register image
  logic [23:0] pair_word [5]; // ADC result images
  logic [11:0] nxt_cmp;     // Fresh comparison results
  logic [9:0]  lvl15;       // Input 15 level
  logic [9:0]  lvl14;       // Input 14 level
  logic        above15;     // Input 15 strictly above threshold
  logic        above14;     // Input 14 strictly above threshold
  ssar_pkg::ssar_scan_t scan_ff; // Scan capture state

  // -----------------------------------------------------------------
  // Shared threshold comparison
  // -----------------------------------------------------------------
  // Equal counts as above for the shared compare
  always_comb
  begin
    for (int i = 0; i < ssar_pkg::NUM_CMP; i++)
    begin
      nxt_cmp[i] = (in_level[i*10 +: 10] >= shared_threshold_level);
    end
  end

  // Latched only on cmp_upd so host reads see a stable snapshot
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cmp_ff <= ssar_pkg::RST_FLAGS[ssar_pkg::CMP_MSB:
                                    ssar_pkg::CMP_LSB];
    end
    else if (cmp_upd)
    begin
      cmp_ff <= nxt_cmp;
    end
  end

  // -----------------------------------------------------------------
  // Matrix scan capture
  // -----------------------------------------------------------------
  // Inputs 14 and 15 own slots 14 and 15, apart from inputs 10 and 11,
  // so a matrix step can never disturb the shared compare
  assign lvl14   = in_level[149:140];
  assign lvl15   = in_level[159:150];
  // Matrix flags use strictly above, unlike the shared compare
  assign above15 = (lvl15 > shared_threshold_level);
  assign above14 = (lvl14 > shared_threshold_level);

  // Scan state: hold marks that a drive step is being captured
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      scan_ff <= ssar_pkg::SSAR_SCAN_IDLE;
    end
    else
    begin
      case (scan_ff)
        ssar_pkg::SSAR_SCAN_IDLE:
        begin
          if (scan_valid)
          begin
            scan_ff <= ssar_pkg::SSAR_SCAN_HOLD;
          end
        end
        ssar_pkg::SSAR_SCAN_HOLD:
        begin
          if (!scan_valid)
          begin
            scan_ff <= ssar_pkg::SSAR_SCAN_IDLE;
          end
        end
        default:
        begin
          scan_ff <= ssar_pkg::SSAR_SCAN_IDLE;
        end
      endcase
    end
  end

  // Each scan step updates only the bit of the grounded drive line;
  // bit k of the one-hot is drive line 4+k
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s15_ff <= ssar_pkg::RST_SCAN;
      s14_ff <= ssar_pkg::RST_SCAN;
    end
    else if (scan_valid)
    begin
      for (int k = 0; k < ssar_pkg::NUM_DRIVE; k++)
      begin
        if (scan_drive_onehot[k])
        begin
          s15_ff[k] <= above15;
          s14_ff[k] <= above14;
        end
      end
    end
  end

  // Combined flag register layout
  assign flags_word = {cmp_ff, s15_ff, s14_ff};

  // -----------------------------------------------------------------
  // ADC result registers
  // -----------------------------------------------------------------
  // Pair p holds inputs 2p and 2p+1
  genvar p;
  generate
    for (p = 0; p < ssar_pkg::NUM_PAIRS; p++)
    begin : g_pair
      ssar_pair_if pif ();
      assign pif.upd       = adc_upd;
      assign pif.code_even = adc_code[p*20 +: 10];
      assign pif.code_odd  = adc_code[p*20+10 +: 10];
      assign pair_word[p]  = pif.word;
      ssar_pair_reg u_pair
      (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pair    (pif)
      );
    end
  endgenerate

  // -----------------------------------------------------------------
  // Read decode
  // -----------------------------------------------------------------
  // Unmapped addresses read as zero and raise addr_err
  always_comb
  begin
    nxt_hit     = 1'b1;
    nxt_rd_data = ssar_pkg::READ_UNMAPPED;
    case (reg_addr)
      ssar_pkg::ADDR_SHARED_THRESHOLD_AND_MATRIX_FLAGS:
      begin
        nxt_rd_data = flags_word;
      end
      ssar_pkg::ADDR_ADC_RESULT_INPUTS_0_1:
      begin
        nxt_rd_data = pair_word[0];
      end
      ssar_pkg::ADDR_ADC_RESULT_INPUTS_2_3:
      begin
        nxt_rd_data = pair_word[1];
      end
      ssar_pkg::ADDR_ADC_RESULT_INPUTS_4_5:
      begin
        nxt_rd_data = pair_word[2];
      end
      ssar_pkg::ADDR_ADC_RESULT_INPUTS_6_7:
      begin
        nxt_rd_data = pair_word[3];
      end
      ssar_pkg::ADDR_ADC_RESULT_INPUTS_8_9:
      begin
        nxt_rd_data = pair_word[4];
      end
      default:
      begin
        nxt_hit = 1'b0;
      end
    endcase
  end

  // -----------------------------------------------------------------
  // Read answer and write rejection
  // -----------------------------------------------------------------
  // Writes never reach storage; they only flag an error
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rd_data_ff  <= ssar_pkg::RST_FLAGS;
      rd_valid_ff <= 1'b0;
      addr_err_ff <= 1'b0;
    end
    else
    begin
      rd_valid_ff <= rd_en;
      addr_err_ff <= (rd_en && !nxt_hit) || wr_en;
      if (rd_en)
      begin
        rd_data_ff <= nxt_rd_data;
      end
    end
  end

  assign rd_data  = rd_data_ff;
  assign rd_valid = rd_valid_ff;
  assign addr_err = addr_err_ff;

  // wr_data and level slots 12, 13 are accepted but not used here
  logic unused_wr;
  assign unused_wr = ^{wr_data, in_level[139:120]};

endmodule

/* File: tb/ssar_host_model.sv */
// Host model: reads and writes the status bank one request at a time
`timescale 1ns/1ps
module ssar_host_model
(
  input  wire logic        clk_sys,
  output logic             rd_en,
  output logic             wr_en,
  output logic [5:0]       reg_addr,
  output logic [23:0]      wr_data,
  input  wire logic [23:0] rd_data,
  input  wire logic        rd_valid,
  input  wire logic        addr_err
);
  // Idle host; address shows the inverse of the last one once released
  initial
  begin
    rd_en = 1'b0;
    wr_en = 1'b0;
    reg_addr = 6'h00;
    wr_data = 24'h000000;
  end

  // One-cycle read, answer sampled after the following edge settles
  task automatic rd(input logic [5:0] a, output logic [23:0] d,
                    output logic v, output logic er);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    reg_addr <= ~a;
    #1 d = rd_data;
    v = rd_valid;
    er = addr_err;
  endtask

  // One-cycle write attempt; the bank holds only read-only places
  task automatic wr(input logic [5:0] a, input logic [23:0] x,
                    output logic er);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    reg_addr <= a;
    wr_data <= x;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    reg_addr <= ~a;
    wr_data <= ~x;
    #1 er = addr_err;
  endtask
endmodule

/* File: tb/ssar_status_bank_checker.sv */
// Checker: port-level properties of the status bank
`timescale 1ns/1ps
module ssar_status_bank_checker
(
  input wire logic         clk_sys,
  input wire logic         rst,
  input wire logic [9:0]   shared_threshold_level,
  input wire logic [159:0] in_level,
  input wire logic         cmp_upd,
  input wire logic         scan_valid,
  input wire logic [5:0]   scan_drive_onehot,
  input wire logic         adc_upd,
  input wire logic [99:0]  adc_code,
  input wire logic         rd_en,
  input wire logic         wr_en,
  input wire logic [5:0]   reg_addr,
  input wire logic [23:0]  wr_data,
  input wire logic [23:0]  rd_data,
  input wire logic         rd_valid,
  input wire logic         addr_err
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Address falls inside the 9h..Eh window
  wire logic mapped = reg_addr >= 6'h09 && reg_addr <= 6'h0E;

  a_reset_clears_out: assert property (disable iff (1'b0) rst |=>
    rd_data == 24'h000000 && !rd_valid && !addr_err) else $error("reset");
  a_valid_needs_read: assert property (rd_valid |-> $past(rd_en))
    else $error("stray valid");
  a_write_flags_err: assert property (wr_en && !rd_en |=>
    addr_err && !rd_valid) else $error("write taken");
  a_unmapped_zero: assert property (rd_en && !wr_en && !mapped |=>
    addr_err && rd_data == 24'h000000) else $error("unmapped read");
  a_mapped_no_err: assert property (rd_en && !wr_en && mapped |=>
    rd_valid && !addr_err) else $error("mapped read");
  a_reserved_read_zero: assert property (rd_en && reg_addr >= 6'h0A &&
    reg_addr <= 6'h0E |=> rd_data[23:20] == 4'h0) else $error("reserved");
  a_even_code_low: assert property (adc_upd ##1 (rd_en &&
    reg_addr == 6'h0A && !adc_upd) |=> rd_data[9:0] == $past(
    adc_code[9:0], 2)) else $error("even code");
  a_odd_code_high: assert property (adc_upd ##1 (rd_en &&
    reg_addr == 6'h0A && !adc_upd) |=> rd_data[19:10] == $past(
    adc_code[19:10], 2)) else $error("odd code");
  a_shared_flag_cmp: assert property (cmp_upd ##1 (rd_en &&
    reg_addr == 6'h09 && !cmp_upd) |=> rd_data[12] == ($past(
    in_level[9:0], 2) >= $past(shared_threshold_level, 2)))
    else $error("shared flag");
endmodule

bind ssar_status_bank ssar_status_bank_checker u_chk
(
  .clk_sys, .rst, .shared_threshold_level, .in_level, .cmp_upd,
  .scan_valid, .scan_drive_onehot, .adc_upd, .adc_code, .rd_en, .wr_en,
  .reg_addr, .wr_data, .rd_data, .rd_valid, .addr_err
);

/* File: tb/testbench.sv */
// Testbench: status bank driven through the host register model
`timescale 1ns/1ps
module testbench;
  logic          clk_sys = 1'b0;
  logic          rst = 1'b1;
  logic [9:0]    thr = 10'h100;     // Shared threshold level
  logic [159:0]  lvl = 160'h0;      // Input levels
  logic [159:0]  nl = 160'h0;       // Next input levels
  logic [99:0]   code = 100'h0;     // ADC codes
  logic [99:0]   nc = 100'h0;       // Next ADC codes
  logic          cmp_upd = 1'b0;
  logic          scan_valid = 1'b0;
  logic          adc_upd = 1'b0;
  logic [5:0]    drive = 6'h00;     // Grounded drive line, one-hot
  logic          rd_en, wr_en, rd_valid, addr_err, v, e;
  logic [5:0]    reg_addr;
  logic [23:0]   wr_data, rd_data, d;
  int            bad_count = 0;
  int            cmp_count = 0;

  ssar_status_bank dut (.clk_sys, .rst, .shared_threshold_level(thr),
    .in_level(lvl), .cmp_upd, .scan_valid, .scan_drive_onehot(drive),
    .adc_upd, .adc_code(code), .rd_en, .wr_en, .reg_addr, .wr_data,
    .rd_data, .rd_valid, .addr_err);
  ssar_host_model host (.clk_sys, .rd_en, .wr_en, .reg_addr, .wr_data,
    .rd_data, .rd_valid, .addr_err);

  always #12.5 clk_sys = ~clk_sys;

  task automatic chk(input logic [23:0] x, input logic [23:0] g);
    cmp_count++;
    if (x !== g)
    begin
      bad_count++;
      $display("mismatch t=%0t exp=%h got=%h", $time, x, g);
    end
  endtask

  // Read right behind a strobe, dropping every strobe at the first edge
  task automatic fire_rd(input logic [5:0] a);
    fork
      host.rd(a, d, v, e);
      begin
        @(posedge clk_sys);
        {cmp_upd, scan_valid, adc_upd} <= 3'h0;
      end
    join
  endtask

  task automatic t_reset();
    for (int a = 9; a <= 14; a++)
    begin
      fire_rd(a[5:0]);
      chk(24'h000000, d);
    end
  endtask

  // Codes 3F0h+n; the read of Ah follows the load at once
  task automatic t_adc();
    for (int n = 0; n < 10; n++)
      nc[n*10 +: 10] = 10'h3F0 + 10'(n);
    @(posedge clk_sys);
    code <= nc;
    adc_upd <= 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      fire_rd(6'h0A + k[5:0]);
      chk({4'h0, 10'h3F1 + 10'(2*k), 10'h3F0 + 10'(2*k)}, d);
      chk(24'h000002, {22'h0, v, e});
    end
  endtask

  // Levels below, equal to and above the threshold in turn
  task automatic t_cmp();
    for (int i = 0; i < 12; i++)
      nl[i*10 +: 10] = 10'h0FF + 10'(i % 3);
    @(posedge clk_sys);
    lvl <= nl;
    cmp_upd <= 1'b1;
    fire_rd(6'h09);
    chk(24'hDB6000, d);
  endtask

  // Back-to-back scan steps; equal level must not count as above.
  // A compare latched with the last step proves inputs 10, 11 apart
  // from inputs 14, 15.
  task automatic t_scan();
    for (int k = 0; k < 6; k++)
    begin
      nl[149:140] = (k % 2 == 0) ? 10'h101 : 10'h100;
      nl[159:150] = (k < 3) ? 10'h101 : 10'h0FF;
      @(posedge clk_sys);
      lvl <= nl;
      drive <= 6'h01 << k;
      scan_valid <= 1'b1;
      cmp_upd <= (k == 5);
    end
    fire_rd(6'h09);
    chk(24'hDB61D5, d);
  endtask

  // Writes refused, contents kept; reads outside the window give zero
  task automatic t_write();
    host.wr(6'h0A, 24'hFFFFFF, e);
    chk(24'h000001, {23'h0, e});
    fire_rd(6'h0A);
    chk(24'h0FC7F0, d);
    for (int a = 8; a < 16; a += 7)
    begin
      fire_rd(a[5:0]);
      chk(24'h000001, {23'h0, e});
      chk(24'h000000, d);
    end
  endtask

  task automatic complete_run();
    $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_adc();
    t_cmp();
    t_scan();
    t_write();
    complete_run();
  end

  // Hang guard, far beyond the roughly 60 cycles the run needs
  initial
  begin
    repeat (4000) @(posedge clk_sys);
    bad_count++;
    complete_run();
  end
endmodule
